// ==== logic/irc_image_roi_crop.sv ====
// Top of the ROI crop block: APB registers, setting checks and the crop engine.
`timescale 1ns/1ns
module irc_image_roi_crop #(
    parameter int PIX_W = 16,
    parameter logic [33:0] MEM_PIXELS = 34'h080000000
) (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Camera frame size for adoption
    input wire logic [irc_pkg::COL_W-1:0] CAM_WIDTH_IN,
    input wire logic [irc_pkg::LINE_W-1:0] CAM_HEIGHT_IN,
    // Camera stream
    input wire logic PIX_VALID_IN,
    input wire logic [PIX_W-1:0] PIX_DATA_IN,
    input wire logic PIX_SOF_IN,
    input wire logic PIX_EOL_IN,
    output logic PIX_READY_OUT,
    // Cropped stream toward DMA
    output logic ROI_VALID_OUT,
    output logic [PIX_W-1:0] ROI_DATA_OUT,
    output logic ROI_SOL_OUT,
    output logic ROI_EOL_OUT,
    output logic ROI_EOF_OUT,
    output logic ACQ_ACTIVE_OUT
);
    import irc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Setting checks

    function automatic logic in_range(input logic [17:0] v, input logic [17:0] lo,
                                      input logic [17:0] hi, input logic [1:0] msk);
        return (v >= lo) && (v <= hi) && ((v[1:0] & msk) == 2'h0);
    endfunction : in_range

    function automatic logic cfg_ok(input logic [COL_W-1:0] w, input logic [LINE_W-1:0] h,
                                    input logic [COL_W-1:0] hs, input logic [COL_W-1:0] vs,
                                    input logic [CTRL_W-1:0] c,
                                    input logic [COL_W-1:0] fc, input logic [LINE_W-1:0] fl,
                                    input logic [33:0] mem);
        logic [17:0] csum;
        logic [17:0] lsum;
        logic [33:0] area;
        logic ok;
        csum = {2'h0, w} + {2'h0, hs};
        lsum = {1'b0, h} + {2'h0, vs};
        area = (34'(fc) * 34'(fl)) << 1;
        ok = in_range({2'h0, w}, MIN_WIDTH, MAX_WIDTH, COL_STEP_MASK);
        ok = ok && in_range({1'b0, h}, MIN_HEIGHT, MAX_HEIGHT, LINE_STEP_MASK);
        ok = ok && in_range({2'h0, hs}, 18'h0, MAX_HSTART, COL_STEP_MASK);
        ok = ok && in_range({2'h0, vs}, 18'h0, MAX_VSTART, LINE_STEP_MASK);
        ok = ok && in_range({2'h0, fc}, MIN_WIDTH, MAX_WIDTH, COL_STEP_MASK);
        ok = ok && in_range({1'b0, fl}, MIN_HEIGHT, MAX_HEIGHT, LINE_STEP_MASK);
        ok = ok && (csum <= MAX_WIDTH);
        ok = ok && (lsum <= MAX_HEIGHT);
        if (c[CTRL_HMIRROR]) begin
            ok = ok && (csum <= MIRROR_MAX_COLS) && ({2'h0, fc} <= MIRROR_MAX_COLS);
            ok = ok && (csum <= {2'h0, fc});
        end
        if (c[CTRL_VMIRROR]) begin
            ok = ok && (lsum <= {1'b0, fl});
            ok = ok && (area <= mem);
        end
        return ok;
    endfunction : cfg_ok

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and candidate values

    logic [COL_W-1:0] width_q, hstart_q, vstart_q, full_cols_q;
    logic [LINE_W-1:0] height_q, full_lines_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [31:0] image_pixels_q;
    logic reject_q, short_frame_q, short_line_q, pready_q;

    logic [COL_W-1:0] cw, chs, cvs, cfc;
    logic [LINE_W-1:0] ch, cfl;
    logic [CTRL_W-1:0] cc;
    logic fit, mapped, is_cfg, accept, start, adopt_ok, apb_wr, apb_acc;
    logic [31:0] rd_data;
    logic short_line_evt, short_frame_evt;

    irc_roi_if roi ();

    // The answer comes one cycle into the access phase; writes land on the edge that ends it.
    assign apb_acc = PSEL_IN & PENABLE_IN & ~pready_q;
    assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & pready_q;

    always_comb begin
        cw = width_q;
        ch = height_q;
        chs = hstart_q;
        cvs = vstart_q;
        cfc = full_cols_q;
        cfl = full_lines_q;
        cc = ctrl_q;
        fit = 1'b1;
        is_cfg = 1'b1;
        unique case (PADDR_IN)
            OFS_WIDTH: begin
                cw = PWDATA_IN[COL_W-1:0];
                fit = (PWDATA_IN[31:COL_W] == '0);
            end
            OFS_HEIGHT: begin
                ch = PWDATA_IN[LINE_W-1:0];
                fit = (PWDATA_IN[31:LINE_W] == '0);
            end
            OFS_HSTART: begin
                chs = PWDATA_IN[COL_W-1:0];
                fit = (PWDATA_IN[31:COL_W] == '0);
            end
            OFS_VSTART: begin
                cvs = PWDATA_IN[COL_W-1:0];
                fit = (PWDATA_IN[31:COL_W] == '0);
            end
            OFS_CTRL: begin
                cc = PWDATA_IN[CTRL_W-1:0];
            end
            OFS_FULL_COLS: begin
                cfc = PWDATA_IN[COL_W-1:0];
                fit = (PWDATA_IN[31:COL_W] == '0);
            end
            OFS_FULL_LINES: begin
                cfl = PWDATA_IN[LINE_W-1:0];
                fit = (PWDATA_IN[31:LINE_W] == '0);
            end
            default: begin
                is_cfg = 1'b0;
            end
        endcase
    end

    assign mapped = is_cfg || (PADDR_IN == OFS_STATUS) || (PADDR_IN == OFS_OUT_WIDTH)
                    || (PADDR_IN == OFS_OUT_HEIGHT) || (PADDR_IN == OFS_IMAGE_PIXELS);
    assign adopt_ok = cfg_ok(CAM_WIDTH_IN, CAM_HEIGHT_IN, hstart_q, vstart_q, cc,
                             full_cols_q, full_lines_q, MEM_PIXELS);
    assign start = apb_wr && (PADDR_IN == OFS_CTRL) && cc[CTRL_RUN] && !ctrl_q[CTRL_RUN];

    always_comb begin
        accept = 1'b0;
        if (ctrl_q[CTRL_RUN]) begin
            // settings frozen while running; only a stop is taken
            accept = (PADDR_IN == OFS_CTRL) && !cc[CTRL_RUN];
        end else if (is_cfg && fit && cfg_ok(cw, ch, chs, cvs, cc, cfc, cfl, MEM_PIXELS)) begin
            accept = 1'b1;
            if ((PADDR_IN == OFS_WIDTH || PADDR_IN == OFS_HEIGHT) && ctrl_q[CTRL_AUTO]) begin
                accept = 1'b0;
            end
            if (start && cc[CTRL_AUTO] && !adopt_ok) begin
                accept = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Setting registers

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            width_q <= WIDTH_RST;
            height_q <= HEIGHT_RST;
        end else if (apb_wr && accept) begin
            if (start && cc[CTRL_AUTO]) begin
                width_q <= CAM_WIDTH_IN;
                height_q <= CAM_HEIGHT_IN;
            end else begin
                width_q <= cw;
                height_q <= ch;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            hstart_q <= HSTART_RST;
            vstart_q <= VSTART_RST;
            full_cols_q <= FULL_COLS_RST;
            full_lines_q <= FULL_LINES_RST;
            ctrl_q <= CTRL_RST;
        end else if (apb_wr && accept) begin
            hstart_q <= chs;
            vstart_q <= cvs;
            full_cols_q <= cfc;
            full_lines_q <= cfl;
            ctrl_q <= ctrl_q[CTRL_RUN] ? {ctrl_q[CTRL_W-1:1], 1'b0} : cc;
        end
    end

    // active window and output size latched at start
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            roi.width <= WIDTH_RST;
            roi.height <= HEIGHT_RST;
            roi.hstart <= HSTART_RST;
            roi.vstart <= VSTART_RST;
            roi.enable <= 1'b0;
            image_pixels_q <= '0;
            ACQ_ACTIVE_OUT <= 1'b0;
        end else if (apb_wr && accept) begin
            roi.enable <= start;
            ACQ_ACTIVE_OUT <= start;
            if (start) begin
                roi.width <= cc[CTRL_AUTO] ? CAM_WIDTH_IN : width_q;
                roi.height <= cc[CTRL_AUTO] ? CAM_HEIGHT_IN : height_q;
                roi.hstart <= hstart_q;
                roi.vstart <= vstart_q;
                image_pixels_q <= cc[CTRL_AUTO] ?
                    32'(CAM_WIDTH_IN * 33'(CAM_HEIGHT_IN)) : 32'(width_q * 33'(height_q));
            end
        end
    end

    // Sticky short frame/line flags; a new event beats a clear in the same cycle. Reject follows the last config write.
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            reject_q <= 1'b0;
            short_frame_q <= 1'b0;
            short_line_q <= 1'b0;
        end else begin
            if (apb_wr && PADDR_IN == OFS_STATUS) begin
                short_frame_q <= short_frame_evt | (short_frame_q & ~PWDATA_IN[ST_SHORT_FRAME]);
                short_line_q <= short_line_evt | (short_line_q & ~PWDATA_IN[ST_SHORT_LINE]);
            end else begin
                short_frame_q <= short_frame_q | short_frame_evt;
                short_line_q <= short_line_q | short_line_evt;
            end
            if (apb_wr && is_cfg) begin
                reject_q <= ~accept;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB read and response

    always_comb begin
        rd_data = '0;
        unique case (PADDR_IN)
            OFS_WIDTH: rd_data = 32'(width_q);
            OFS_HEIGHT: rd_data = 32'(height_q);
            OFS_HSTART: rd_data = 32'(hstart_q);
            OFS_VSTART: rd_data = 32'(vstart_q);
            OFS_CTRL: rd_data = 32'(ctrl_q);
            OFS_FULL_COLS: rd_data = 32'(full_cols_q);
            OFS_FULL_LINES: rd_data = 32'(full_lines_q);
            OFS_STATUS: rd_data = 32'({short_line_q, short_frame_q, ctrl_q[CTRL_RUN], reject_q});
            OFS_OUT_WIDTH: rd_data = 32'(roi.width);
            OFS_OUT_HEIGHT: rd_data = 32'(roi.height);
            OFS_IMAGE_PIXELS: rd_data = image_pixels_q;
            default: rd_data = '0;
        endcase
    end

    assign PREADY_OUT = pready_q;

    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pready_q <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= '0;
        end else begin
            pready_q <= apb_acc;
            PSLVERR_OUT <= apb_acc & ~mapped;
            if (apb_acc && !PWRITE_IN) begin
                PRDATA_OUT <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crop engine

    irc_crop_engine #(
        .PIX_W(PIX_W)
    ) irc_crop_engine_inst (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RST_N_IN),
        .roi(roi.sink),
        .pix_valid_in(PIX_VALID_IN),
        .pix_data_in(PIX_DATA_IN),
        .pix_sof_in(PIX_SOF_IN),
        .pix_eol_in(PIX_EOL_IN),
        .pix_ready_out(PIX_READY_OUT),
        .roi_valid_out(ROI_VALID_OUT),
        .roi_data_out(ROI_DATA_OUT),
        .roi_sol_out(ROI_SOL_OUT),
        .roi_eol_out(ROI_EOL_OUT),
        .roi_eof_out(ROI_EOF_OUT),
        .short_line_out(short_line_evt),
        .short_frame_out(short_frame_evt)
    );
endmodule : irc_image_roi_crop

// ==== logic/irc_pkg.sv ====
// Constants shared by the ROI crop block.
package irc_pkg;
    localparam int COL_W = 16;
    localparam int LINE_W = 17;
    localparam int CTRL_W = 4;

    // Limits, held at a common 18-bit width for the range checks; the two step masks are 2 bits.
    localparam logic [17:0] MIN_WIDTH = 18'h00008;
    localparam logic [17:0] MAX_WIDTH = 18'h0C000;
    localparam logic [17:0] MAX_HSTART = 18'h0BFF8;
    localparam logic [17:0] MIN_HEIGHT = 18'h00002;
    localparam logic [17:0] MAX_HEIGHT = 18'h10000;
    localparam logic [17:0] MAX_VSTART = 18'h0FFFF;
    localparam logic [17:0] MIRROR_MAX_COLS = 18'h02000;
    localparam logic [1:0] COL_STEP_MASK = 2'h3;
    localparam logic [1:0] LINE_STEP_MASK = 2'h0;

    // Reset values.
    localparam logic [COL_W-1:0] WIDTH_RST = 16'h0400;
    localparam logic [LINE_W-1:0] HEIGHT_RST = 17'h00400;
    localparam logic [COL_W-1:0] HSTART_RST = 16'h0000;
    localparam logic [COL_W-1:0] VSTART_RST = 16'h0000;
    localparam logic [COL_W-1:0] FULL_COLS_RST = 16'h0400;
    localparam logic [LINE_W-1:0] FULL_LINES_RST = 17'h00400;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

    // Register byte offsets.
    localparam logic [7:0] OFS_WIDTH = 8'h00;
    localparam logic [7:0] OFS_HEIGHT = 8'h04;
    localparam logic [7:0] OFS_HSTART = 8'h08;
    localparam logic [7:0] OFS_VSTART = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_FULL_COLS = 8'h14;
    localparam logic [7:0] OFS_FULL_LINES = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_OUT_WIDTH = 8'h20;
    localparam logic [7:0] OFS_OUT_HEIGHT = 8'h24;
    localparam logic [7:0] OFS_IMAGE_PIXELS = 8'h28;

    // Control and status bit positions.
    localparam int CTRL_RUN = 0;
    localparam int CTRL_HMIRROR = 1;
    localparam int CTRL_VMIRROR = 2;
    localparam int CTRL_AUTO = 3;
    localparam int ST_REJECT = 0;
    localparam int ST_RUNNING = 1;
    localparam int ST_SHORT_FRAME = 2;
    localparam int ST_SHORT_LINE = 3;
endpackage : irc_pkg

// ==== logic/irc_roi_if.sv ====
// Active ROI window passed from the register side to the crop engine.
`timescale 1ns/1ns
interface irc_roi_if;
    logic [irc_pkg::COL_W-1:0] hstart;
    logic [irc_pkg::COL_W-1:0] vstart;
    logic [irc_pkg::COL_W-1:0] width;
    logic [irc_pkg::LINE_W-1:0] height;
    logic enable;

    modport src (output hstart, output vstart, output width, output height, output enable);
    modport sink (input hstart, input vstart, input width, input height, input enable);
endinterface : irc_roi_if

// ==== logic/irc_crop_engine.sv ====
// Pixel stream crop engine: window selection and short line padding.
`timescale 1ns/1ns
module irc_crop_engine #(
    parameter int PIX_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Active window
    irc_roi_if.sink roi,
    // Camera stream
    input wire logic pix_valid_in,
    input wire logic [PIX_W-1:0] pix_data_in,
    input wire logic pix_sof_in,
    input wire logic pix_eol_in,
    output logic pix_ready_out,
    // Cropped stream
    output logic roi_valid_out,
    output logic [PIX_W-1:0] roi_data_out,
    output logic roi_sol_out,
    output logic roi_eol_out,
    output logic roi_eof_out,
    // Events
    output logic short_line_out,
    output logic short_frame_out
);
    import irc_pkg::*;

    typedef enum {CROP_PASS, CROP_PAD} irc_crop_state_t;

    irc_crop_state_t state_q, state_d;
    logic [COL_W-1:0] col_q, cur_col, pad_col_q, next_col;
    logic [LINE_W-1:0] line_q, cur_line, pad_line_q;
    logic [COL_W:0] hend;
    logic [LINE_W:0] vend;
    logic frame_q, take, win_v, win, col_last, line_last, need_pad, pad_last, eof_d;

    assign hend = {1'b0, roi.hstart} + {1'b0, roi.width};
    assign vend = {1'b0, roi.height} + {2'b00, roi.vstart};
    assign cur_col = pix_sof_in ? '0 : col_q;
    assign cur_line = pix_sof_in ? '0 : line_q;
    assign next_col = cur_col + 16'h0001;
    assign take = pix_valid_in & pix_ready_out & roi.enable & (pix_sof_in | frame_q);
    assign win_v = ({1'b0, cur_line} >= {2'b00, roi.vstart}) && ({1'b0, cur_line} < vend);
    assign win = win_v && (cur_col >= roi.hstart) && ({1'b0, cur_col} < hend);
    assign col_last = ({1'b0, cur_col} == hend - 17'h00001);
    assign line_last = ({1'b0, cur_line} == vend - 18'h00001);
    assign pad_last = ({1'b0, pad_col_q} == hend - 17'h00001);
    assign need_pad = take & pix_eol_in & win_v & ({1'b0, next_col} < hend);
    assign eof_d = (state_q == CROP_PAD) ?
        (roi.enable && pad_last && ({1'b0, pad_line_q} == vend - 18'h00001)) :
        (take & win & col_last & line_last);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CROP_PASS: begin
                if (need_pad) begin
                    state_d = CROP_PAD;
                end
            end
            CROP_PAD: begin
                // A stop ends padding at once, so nothing leaves while stopped.
                if (pad_last || !roi.enable) begin
                    state_d = CROP_PASS;
                end
            end
        endcase
    end

    // Input is stalled while padding so no camera pixel is lost.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= CROP_PASS;
            pix_ready_out <= 1'b1;
        end else begin
            state_q <= state_d;
            pix_ready_out <= (state_d == CROP_PASS);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            col_q <= '0;
            line_q <= '0;
        end else if (take) begin
            col_q <= pix_eol_in ? '0 : next_col;
            line_q <= pix_eol_in ? cur_line + 17'h00001 : cur_line;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pad_col_q <= '0;
            pad_line_q <= '0;
        end else if (need_pad) begin
            pad_col_q <= (next_col < roi.hstart) ? roi.hstart : next_col;
            pad_line_q <= cur_line;
        end else if (state_q == CROP_PAD) begin
            pad_col_q <= pad_col_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frame_q <= 1'b0;
            short_frame_out <= 1'b0;
        end else begin
            short_frame_out <= take & pix_sof_in & frame_q;
            if (eof_d || !roi.enable) begin
                frame_q <= 1'b0;
            end else if (take & pix_sof_in) begin
                frame_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            roi_valid_out <= 1'b0;
            roi_data_out <= '0;
            roi_sol_out <= 1'b0;
            roi_eol_out <= 1'b0;
            roi_eof_out <= 1'b0;
            short_line_out <= 1'b0;
        end else begin
            short_line_out <= need_pad;
            roi_eof_out <= eof_d;
            if (state_q == CROP_PAD) begin
                roi_valid_out <= roi.enable;
                roi_sol_out <= roi.enable && (pad_col_q == roi.hstart);
                roi_eol_out <= roi.enable && pad_last;
            end else begin
                roi_valid_out <= take & win;
                roi_data_out <= pix_data_in;
                roi_sol_out <= take & win & (cur_col == roi.hstart);
                roi_eol_out <= take & win & col_last;
            end
        end
    end
endmodule : irc_crop_engine

// ==== test/irc_roi_crop_monitor.sv ====
// Port checker for the ROI crop top, bound to every instance.
`timescale 1ns/1ns
module irc_roi_crop_monitor (
    // Clock, reset and bus
    input wire logic CORE_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // Streams
    input wire logic PIX_READY_OUT,
    input wire logic ROI_VALID_OUT,
    input wire logic ROI_SOL_OUT,
    input wire logic ROI_EOL_OUT,
    input wire logic ROI_EOF_OUT,
    input wire logic ACQ_ACTIVE_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    a_ready_one_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
        else $error("bus answer not one cycle after access");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("bus ready held too long");
    a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("bus error without ready");
    a_marks_valid: assert property (ROI_SOL_OUT || ROI_EOL_OUT |-> ROI_VALID_OUT)
        else $error("line mark without pixel");
    a_frame_end: assert property (ROI_EOF_OUT |-> ROI_EOL_OUT)
        else $error("frame end not on line end");
    a_stopped_quiet: assert property (!ACQ_ACTIVE_OUT [*2] |-> !ROI_VALID_OUT)
        else $error("pixel out while stopped");
    a_pad_steady: assert property (ACQ_ACTIVE_OUT && !PIX_READY_OUT &&
        $past(!PIX_READY_OUT) |-> ROI_VALID_OUT) else $error("gap while padding");
    a_pad_ends_line: assert property (ACQ_ACTIVE_OUT && $rose(PIX_READY_OUT) |->
        ROI_EOL_OUT) else $error("padding ended off line end");
    cover property (ROI_EOF_OUT);
    cover property ($fell(PIX_READY_OUT));
    cover property (PSLVERR_OUT);
endmodule : irc_roi_crop_monitor
////////////////////////////////////////////////////////////////////////////////
bind irc_image_roi_crop irc_roi_crop_monitor irc_roi_crop_monitor_inst (.CORE_CLK_IN,
    .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT, .PSLVERR_OUT, .PIX_READY_OUT,
    .ROI_VALID_OUT, .ROI_SOL_OUT, .ROI_EOL_OUT, .ROI_EOF_OUT, .ACQ_ACTIVE_OUT);

// ==== test/irc_cam_model.sv ====
// Camera stream source feeding the crop block.
`timescale 1ns/1ns
module irc_cam_model (
    // Clock and flow control
    input wire logic clk_in,
    input wire logic ready_in,
    // Pixel stream
    output logic valid_out,
    output logic [15:0] data_out,
    output logic sof_out,
    output logic eol_out
);
    int seed = 32'hD93F0559;
    logic rdy_s;
    initial {valid_out, data_out, sof_out, eol_out} = 19'h00000;
    // Ready only moves on a rising edge, so this is its value at the next one.
    always @(negedge clk_in) rdy_s = ready_in;
    // lines may end before the window does.
    task automatic frame(input int cols, input int lines);
        for (int l = 0; l < lines; l++) begin
            for (int c = 0; c < cols; c++) begin
                // Random idle gaps; an idle bus shows inverted data, not stale pixels.
                if ($random(seed) % 3 == 0) begin
                    valid_out <= 1'b0;
                    data_out <= ~data_out;
                    @(posedge clk_in);
                end
                valid_out <= 1'b1;
                data_out <= {l[7:0], c[7:0]};
                sof_out <= (l == 0 && c == 0);
                eol_out <= (c == cols - 1);
                do @(posedge clk_in); while (rdy_s !== 1'b1);
            end
        end
        {valid_out, sof_out, eol_out} <= 3'h0;
        data_out <= ~data_out;
        @(posedge clk_in);
    endtask : frame
endmodule : irc_cam_model

// ==== test/irc_image_roi_crop_tb.sv ====
// Self-checking bench for the ROI crop block.
`timescale 1ns/1ns
module irc_image_roi_crop_tb;
    import irc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwrite = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata, prd_s;
    logic [15:0] cam_w = 16'h0010, pix_d, rdata;
    logic [16:0] cam_h = 17'h00004;
    logic pready, perr, pix_v, pix_sof, pix_eol, pix_rdy, rv, rsol, reol, reof, acq;
    logic prdy_s, perr_s;
    logic [19:0] ev, exp_q[$];
    int fail_count = 0, checks_done = 0, cycles = 0;
    int rst_v[8] = '{1024, 1024, 0, 0, 0, 1024, 1024, 0};
    int tbl[28][3] = '{'{0,6,1}, '{0,10,1}, '{0,49152,0}, '{8,4,1}, '{0,8,0},
        '{8,49144,0}, '{8,2,1}, '{8,0,0}, '{4,65536,0}, '{12,1,1}, '{4,2,0},
        '{12,65534,0}, '{12,0,0}, '{20,8192,0}, '{16,2,0}, '{0,8196,1}, '{20,64,0},
        '{0,64,0}, '{8,4,1}, '{0,8,0}, '{16,0,0}, '{16,4,1}, '{24,16,0}, '{16,4,0},
        '{4,17,1}, '{16,8,0}, '{0,16,1}, '{16,0,0}};
    irc_image_roi_crop #(.MEM_PIXELS(34'h000010000)) irc_image_roi_crop_inst (
        .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(perr), .CAM_WIDTH_IN(cam_w), .CAM_HEIGHT_IN(cam_h),
        .PIX_VALID_IN(pix_v), .PIX_DATA_IN(pix_d), .PIX_SOF_IN(pix_sof), .PIX_EOL_IN(pix_eol),
        .PIX_READY_OUT(pix_rdy), .ROI_VALID_OUT(rv), .ROI_DATA_OUT(rdata), .ROI_SOL_OUT(rsol),
        .ROI_EOL_OUT(reol), .ROI_EOF_OUT(reof), .ACQ_ACTIVE_OUT(acq));
    irc_cam_model irc_cam_model_inst (.clk_in(clk), .ready_in(pix_rdy), .valid_out(pix_v),
        .data_out(pix_d), .sof_out(pix_sof), .eol_out(pix_eol));
    always #20 clk = ~clk;
    // Outputs move on rising edges; the falling edge sees them settled.
    always @(negedge clk) {prdy_s, perr_s, prd_s} = {pready, perr, prdata};
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pen, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy_s !== 1'b1);
        {rd, err} = {prd_s, perr_s};
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask : apb
    task automatic cfg(input int a, input int d, input int rej);
        apb(1'b1, 8'(a), d);
        apb(1'b0, OFS_STATUS, 0);
        chk({31'h0, rd[ST_REJECT]}, rej);
    endtask : cfg
    task automatic expect_frame(input int cols, input int hs, input int vs);
        for (int l = vs; l < vs + 2; l++)
            for (int c = hs; c < hs + 8; c++)
                exp_q.push_back({c >= cols, c == hs, c == hs + 7, c == hs + 7 && l == vs + 1,
                    l[7:0], c[7:0]});
    endtask : expect_frame
    always @(negedge clk) if (rst_n && rv !== 1'b0) begin
        chk(32'(exp_q.size() != 0), 32'h1);
        ev = (exp_q.size() != 0) ? exp_q.pop_front() : 20'h0;
        chk({29'h0, rsol, reol, reof}, {29'h0, ev[18:16]});
        if (!ev[19]) chk({16'h0, rdata}, {16'h0, ev[15:0]});
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 0);
            chk(rd, rst_v[i]);
        end
        apb(1'b0, 8'h40, 0);
        chk({rd[30:0], err}, 32'h1);
        $display("reset and map test done");
        foreach (tbl[i]) cfg(tbl[i][0], tbl[i][1], tbl[i][2]);
        $display("limit test done");
        cfg(8, 4, 0);
        cfg(12, 1, 0);
        cfg(16, 1, 0);
        expect_frame(16, 4, 1);
        irc_cam_model_inst.frame(16, 4);
        expect_frame(10, 4, 1);
        irc_cam_model_inst.frame(10, 4);
        for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge clk);
        chk(32'(exp_q.size()), 0);
        chk({31'h0, acq}, 32'h1);
        apb(1'b0, OFS_STATUS, 0);
        chk({29'h0, rd[3:1]}, 32'h5);
        apb(1'b1, OFS_STATUS, 32'hC);
        apb(1'b0, OFS_STATUS, 0);
        chk({29'h0, rd[3:1]}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(32 + 4 * i), 0);
            chk(rd, i == 0 ? 8 : i == 1 ? 2 : 16);
        end
        cfg(8, 0, 1);
        cfg(16, 0, 0);
        chk({31'h0, acq}, 32'h0);
        $display("stream test done");
        cam_w <= 16'h000C;
        cam_h <= 17'h00003;
        cfg(16, 9, 0);
        apb(1'b0, OFS_WIDTH, 0);
        chk(rd, 12);
        cfg(16, 0, 0);
        $display("adoption test done");
        finish_test();
    end
endmodule : irc_image_roi_crop_tb
